// file: rtl/embpc_cfg.svh
// Timing counts, pin positions and limits of the external memory bus pin control.
`ifndef EMBPC_CFG_SVH
`define EMBPC_CFG_SVH
`define EMBPC_OSC_PER_MC 4'hc
`define EMBPC_PHASE_LAST 4'hb
`define EMBPC_SLOT_LEN 4'h6
`define EMBPC_ALE_LEN 4'h2
`define EMBPC_PROGRAM_FETCH_STROBE_FIRST 4'h2
`define EMBPC_PROGRAM_FETCH_STROBE_LAST 4'h4
`define EMBPC_STB_FIRST 4'h3
`define EMBPC_STB_LAST 4'ha
`define EMBPC_RST_MC 5'h02
`define EMBPC_RST_CYCLES 5'h18
`define EMBPC_INT_ROM_TOP 16'h1000
`define EMBPC_P3_RXD 0
`define EMBPC_P3_TXD 1
`define EMBPC_P3_IRQ0 2
`define EMBPC_P3_IRQ1 3
`define EMBPC_P3_CNT0 4
`define EMBPC_P3_CNT1 5
`define EMBPC_P3_WR 6
`define EMBPC_P3_RD 7
`endif

// file: rtl/embpc_phase.sv
// Oscillator period counter that divides each machine cycle into twelve phases.
`include "embpc_cfg.svh"
`default_nettype none
module embpc_phase (
    input wire logic clock,
    input wire logic reset,
    output embpc_pkg::embpc_phase_t phase_q,
    output embpc_pkg::embpc_phase_t phase_next
);
    import embpc_pkg::*;

    always_comb begin
        if (phase_q == `EMBPC_PHASE_LAST) begin
            phase_next = 4'h0;
        end else begin
            phase_next = phase_q + 4'h1;
        end
    end

    // Twelve oscillator periods make one machine cycle. [RL21]
    // Reset parks the counter on the last phase so that the first edge after reset opens a full slot.
    always_ff @(posedge clock) begin
        if (reset) begin
            phase_q <= `EMBPC_PHASE_LAST;
        end else begin
            phase_q <= phase_next;
        end
    end

    a_phase_wrap: assert property (@(posedge clock) disable iff (reset) // [RL21]
        phase_q == `EMBPC_PHASE_LAST |=> phase_q == 4'h0) else $error("phase did not wrap after twelve periods");
endmodule
`default_nettype wire

// file: rtl/embpc_pkg.sv
// Types shared by the external memory bus pin control.
`default_nettype none
package embpc_pkg;
    typedef logic [7:0] embpc_byte_t;
    typedef logic [15:0] embpc_addr_t;
    typedef logic [3:0] embpc_phase_t;
    typedef enum logic [2:0] {
        EMBPC_IDLE,
        EMBPC_FETCH_INT,
        EMBPC_FETCH_EXT,
        EMBPC_DATA_RD,
        EMBPC_DATA_WR
    } embpc_cycle_e;
endpackage
`default_nettype wire

// file: rtl/embpc_top.sv
// External memory bus and alternate pin function control of the microcontroller.
// Function
// RL1: Reset pin high for two machine cycles resets the device; holder keeps it that long.
// RL2: Address latch strobe lets external memory capture the low address byte.
// RL3: Address latch strobe pulses every six periods, omitted during data access.
// RL4: Program fetch strobe pulses every six periods on external fetches only.
// RL5: Program fetch strobe stays high while executing from internal memory.
// RL6: Fetch select high: internal fetch below 4096, external otherwise.
// RL7: Fetch select low: every fetch is external.
// RL8: Port zero carries low address then data, time multiplexed.
// RL9: Port two carries the high address byte during external accesses.
// RL10: Write strobe on port three bit six; memory latches port zero.
// RL11: Read strobe on port three bit seven; memory drives port zero.
// RL12: Port three alternate function works only while its latch bit is one; bit zero, and bit one in loop mode, ignore their latch bits.
// RL13: Outside loop mode, port one bit six is active-low request to send.
// RL14: Outside loop mode, receiver drives port one bit seven low when ready.
// RL15: Bit zero steers bit one direction, or is receive input in loop and diagnostic.
// RL16: In loop mode port three bit one is the transmit output.
// RL17: Zero in the port three bit one latch selects diagnostic mode.
// RL18: Port three bits two and three are interrupt or counter gate inputs.
// RL19: Port three bit four is the counter zero count input.
// RL20: Port three bit five is counter one input or serial bit clock.
// RL21: One machine cycle is twelve periods; strobes pulse twice per cycle.
`include "embpc_cfg.svh"
`default_nettype none
module embpc_top (
    input wire logic clock,
    input wire logic reset,
    input wire logic reset_pin,
    output logic core_reset,
    input wire logic external_fetch_select,
    input wire logic fetch_req,
    input wire embpc_pkg::embpc_addr_t fetch_pc,
    output logic fetch_ready,
    output logic fetch_internal,
    output embpc_pkg::embpc_byte_t fetch_data,
    input wire logic data_req,
    input wire logic data_write,
    input wire embpc_pkg::embpc_addr_t data_addr,
    input wire embpc_pkg::embpc_byte_t data_wdata,
    output logic data_ready,
    output embpc_pkg::embpc_byte_t data_rdata,
    output logic address_latch_strobe,
    output logic program_fetch_strobe_n,
    input wire embpc_pkg::embpc_byte_t p0_in,
    output embpc_pkg::embpc_byte_t p0_out,
    output logic p0_oe,
    input wire embpc_pkg::embpc_byte_t p2_latch,
    output embpc_pkg::embpc_byte_t p2_out,
    input wire embpc_pkg::embpc_byte_t p3_latch,
    input wire embpc_pkg::embpc_byte_t p3_in,
    output embpc_pkg::embpc_byte_t p3_out,
    output logic p3_0_oe,
    output logic p3_1_oe,
    input wire logic loop_mode,
    input wire logic tx_ready,
    input wire logic serial_tx_bit,
    input wire logic serial_tx_enable,
    output logic serial_rx_bit,
    output logic diagnostic_mode,
    input wire logic p1_cts_n,
    output logic p1_rts_n,
    output logic clear_to_send,
    output logic ext_irq_zero,
    output logic ext_irq_one,
    output logic counter_zero_input,
    output logic counter_one_input,
    output logic serial_clock
);
    import embpc_pkg::*;

    embpc_phase_t phase_q;
    embpc_phase_t phase_next;
    embpc_cycle_e cycle_q;
    embpc_cycle_e cycle_d;
    embpc_addr_t addr_q;
    embpc_addr_t addr_d;
    embpc_byte_t wdata_q;
    embpc_byte_t wdata_d;
    logic [4:0] rst_cnt_q;
    logic rst_hold_q;
    logic rst_core;
    logic slot_begin;
    logic ale_q;
    logic program_fetch_strobe_n_q;
    logic rd_n_q;
    logic wr_n_q;
    embpc_byte_t p0_out_q;
    logic p0_oe_q;
    embpc_byte_t p2_out_q;
    logic fetch_ready_q;
    logic fetch_internal_q;
    embpc_byte_t fetch_data_q;
    logic data_ready_q;
    embpc_byte_t data_rdata_q;
    logic irq0_q;
    logic irq1_q;
    logic cnt0_q;
    logic cnt1_q;
    logic sclk_q;
    logic rx_q;
    logic cts_q;
    logic rts_n_q;

    function automatic embpc_phase_t slot_pos(input embpc_phase_t p);
        if (p >= `EMBPC_SLOT_LEN) begin
            slot_pos = p - `EMBPC_SLOT_LEN;
        end else begin
            slot_pos = p;
        end
    endfunction

    function automatic logic is_data(input embpc_cycle_e c);
        is_data = (c == EMBPC_DATA_RD) || (c == EMBPC_DATA_WR);
    endfunction

    function automatic logic is_ext(input embpc_cycle_e c);
        is_ext = (c == EMBPC_FETCH_EXT) || is_data(c);
    endfunction

    // Internal fetch only with the select high and the counter below the internal top. [RL6] [RL7]
    function automatic logic fetch_is_internal(input logic sel, input embpc_addr_t pc);
        fetch_is_internal = sel && (pc < `EMBPC_INT_ROM_TOP);
    endfunction

    // A high reset pin for two full machine cycles takes the device into reset. [RL1]
    always_ff @(posedge clock) begin
        if (reset || !reset_pin) begin
            rst_cnt_q <= 5'h00;
        end else if (rst_cnt_q != `EMBPC_RST_CYCLES) begin
            rst_cnt_q <= rst_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || !reset_pin) begin
            rst_hold_q <= 1'b0;
        end else if (rst_cnt_q == `EMBPC_RST_CYCLES - 5'h01) begin
            rst_hold_q <= 1'b1; // [RL1]
        end
    end

    assign rst_core = reset || rst_hold_q;
    assign core_reset = rst_hold_q;

    embpc_phase u_phase (
        .clock(clock),
        .reset(rst_core),
        .phase_q(phase_q),
        .phase_next(phase_next)
    );

    assign slot_begin = (phase_next == 4'h0) || (phase_next == `EMBPC_SLOT_LEN);

    // Data cycles start on a machine cycle boundary and occupy both slots of it.
    always_comb begin
        cycle_d = cycle_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        if (slot_begin && !(is_data(cycle_q) && phase_next == `EMBPC_SLOT_LEN)) begin
            if (data_req && phase_next == 4'h0) begin
                cycle_d = data_write ? EMBPC_DATA_WR : EMBPC_DATA_RD;
                addr_d = data_addr;
                wdata_d = data_wdata;
            end else if (fetch_req) begin
                cycle_d = fetch_is_internal(external_fetch_select, fetch_pc) ? EMBPC_FETCH_INT
                                                                               : EMBPC_FETCH_EXT; // [RL6] [RL7]
                addr_d = fetch_pc;
            end else begin
                cycle_d = EMBPC_IDLE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst_core) begin
            cycle_q <= EMBPC_IDLE;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else begin
            cycle_q <= cycle_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    // Strobes follow the upcoming phase so that they change on the same edge as the phase they belong to.
    always_ff @(posedge clock) begin
        if (rst_core) begin
            ale_q <= 1'b0;
            program_fetch_strobe_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            ale_q <= (slot_pos(phase_next) < `EMBPC_ALE_LEN)
                     && !(is_data(cycle_d) && phase_next >= `EMBPC_SLOT_LEN); // [RL2] [RL3] [RL21]
            program_fetch_strobe_n_q <= !(cycle_d == EMBPC_FETCH_EXT && slot_pos(phase_next) >= `EMBPC_PROGRAM_FETCH_STROBE_FIRST
                          && slot_pos(phase_next) <= `EMBPC_PROGRAM_FETCH_STROBE_LAST); // [RL4] [RL5]
            rd_n_q <= !(cycle_d == EMBPC_DATA_RD && phase_next >= `EMBPC_STB_FIRST
                        && phase_next <= `EMBPC_STB_LAST); // [RL11]
            wr_n_q <= !(cycle_d == EMBPC_DATA_WR && phase_next >= `EMBPC_STB_FIRST
                        && phase_next <= `EMBPC_STB_LAST); // [RL10]
        end
    end

    // During external accesses port zero drives the low address while the latch strobe is high, then write data.
    always_ff @(posedge clock) begin
        if (rst_core) begin
            p0_oe_q <= 1'b0;
            p0_out_q <= 8'hff;
            p2_out_q <= 8'hff;
        end else begin
            if (is_ext(cycle_d) && slot_pos(phase_next) < `EMBPC_ALE_LEN && phase_next < `EMBPC_SLOT_LEN) begin
                p0_oe_q <= 1'b1; // [RL8]
                p0_out_q <= addr_d[7:0];
            end else if (cycle_d == EMBPC_FETCH_EXT && slot_pos(phase_next) < `EMBPC_ALE_LEN) begin
                p0_oe_q <= 1'b1; // [RL8]
                p0_out_q <= addr_d[7:0];
            end else if (cycle_d == EMBPC_DATA_WR && phase_next >= `EMBPC_ALE_LEN) begin
                p0_oe_q <= 1'b1; // [RL8] [RL10]
                p0_out_q <= wdata_d;
            end else begin
                p0_oe_q <= 1'b0;
                p0_out_q <= 8'hff;
            end
            p2_out_q <= is_ext(cycle_d) ? addr_d[15:8] : p2_latch; // [RL9]
        end
    end

    // Fetched and read bytes are taken at the last strobe phase.
    always_ff @(posedge clock) begin
        if (rst_core) begin
            fetch_ready_q <= 1'b0;
            fetch_internal_q <= 1'b0;
            fetch_data_q <= 8'h00;
            data_ready_q <= 1'b0;
            data_rdata_q <= 8'h00;
        end else begin
            fetch_ready_q <= (cycle_q == EMBPC_FETCH_EXT || cycle_q == EMBPC_FETCH_INT)
                             && slot_pos(phase_q) == `EMBPC_PROGRAM_FETCH_STROBE_LAST;
            if ((cycle_q == EMBPC_FETCH_EXT || cycle_q == EMBPC_FETCH_INT)
                && slot_pos(phase_q) == `EMBPC_PROGRAM_FETCH_STROBE_LAST) begin
                fetch_internal_q <= cycle_q == EMBPC_FETCH_INT;
                if (cycle_q == EMBPC_FETCH_EXT) begin
                    fetch_data_q <= p0_in;
                end
            end
            data_ready_q <= is_data(cycle_q) && phase_q == `EMBPC_STB_LAST;
            if (cycle_q == EMBPC_DATA_RD && phase_q == `EMBPC_STB_LAST) begin
                data_rdata_q <= p0_in; // [RL11]
            end
        end
    end

    // Alternate inputs are seen only while their port three latch bit is one.
    always_ff @(posedge clock) begin
        if (rst_core) begin
            irq0_q <= 1'b1;
            irq1_q <= 1'b1;
            cnt0_q <= 1'b0;
            cnt1_q <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            irq0_q <= p3_latch[`EMBPC_P3_IRQ0] ? p3_in[`EMBPC_P3_IRQ0] : 1'b1; // [RL12] [RL18]
            irq1_q <= p3_latch[`EMBPC_P3_IRQ1] ? p3_in[`EMBPC_P3_IRQ1] : 1'b1; // [RL12] [RL18]
            cnt0_q <= p3_latch[`EMBPC_P3_CNT0] && p3_in[`EMBPC_P3_CNT0]; // [RL12] [RL19]
            cnt1_q <= p3_latch[`EMBPC_P3_CNT1] && p3_in[`EMBPC_P3_CNT1]; // [RL12] [RL20]
            sclk_q <= p3_latch[`EMBPC_P3_CNT1] && p3_in[`EMBPC_P3_CNT1]; // [RL12] [RL20]
        end
    end

    // Serial link pins: direction control, loop transmit and diagnostic receive.
    always_ff @(posedge clock) begin
        if (rst_core) begin
            rx_q <= 1'b1;
            cts_q <= 1'b0;
            rts_n_q <= 1'b1;
        end else begin
            if (loop_mode || diagnostic_mode) begin
                rx_q <= p3_in[`EMBPC_P3_RXD]; // [RL15]
            end else begin
                rx_q <= p3_in[`EMBPC_P3_TXD]; // [RL15]
            end
            cts_q <= !loop_mode && !p1_cts_n; // [RL14]
            rts_n_q <= loop_mode || !tx_ready; // [RL13]
        end
    end

    assign diagnostic_mode = !p3_latch[`EMBPC_P3_TXD]; // [RL17]
    assign p3_0_oe = !loop_mode && !diagnostic_mode; // [RL15]
    assign p3_1_oe = loop_mode ? 1'b1 : (!diagnostic_mode && serial_tx_enable); // [RL15] [RL16]
    // Port three pins without a serial or strobe role show their latch bits.
    always_comb begin
        p3_out = p3_latch;
        p3_out[`EMBPC_P3_RXD] = serial_tx_enable; // [RL15]
        p3_out[`EMBPC_P3_TXD] = serial_tx_bit; // [RL16]
        p3_out[`EMBPC_P3_WR] = p3_latch[`EMBPC_P3_WR] && wr_n_q; // [RL10] [RL12]
        p3_out[`EMBPC_P3_RD] = p3_latch[`EMBPC_P3_RD] && rd_n_q; // [RL11] [RL12]
    end

    assign address_latch_strobe = ale_q;
    assign program_fetch_strobe_n = program_fetch_strobe_n_q;
    assign p0_out = p0_out_q;
    assign p0_oe = p0_oe_q;
    assign p2_out = p2_out_q;
    assign fetch_ready = fetch_ready_q;
    assign fetch_internal = fetch_internal_q;
    assign fetch_data = fetch_data_q;
    assign data_ready = data_ready_q;
    assign data_rdata = data_rdata_q;
    assign ext_irq_zero = irq0_q;
    assign ext_irq_one = irq1_q;
    assign counter_zero_input = cnt0_q;
    assign counter_one_input = cnt1_q;
    assign serial_clock = sclk_q;
    assign serial_rx_bit = rx_q;
    assign clear_to_send = cts_q;
    assign p1_rts_n = rts_n_q;

    a_reset_entry: assert property (@(posedge clock) disable iff (reset) // [RL1]
        reset_pin [*8] ##0 (rst_cnt_q == 5'h17) |=> core_reset) else $error("reset pin hold did not reset");
    a_ale_width: assert property (@(posedge clock) disable iff (rst_core) // [RL3]
        $rose(ale_q) |=> ale_q ##1 !ale_q) else $error("address latch strobe not two periods");
    a_ale_period: assert property (@(posedge clock) disable iff (rst_core) // [RL3] [RL21]
        $rose(ale_q) && cycle_q != EMBPC_DATA_RD && cycle_q != EMBPC_DATA_WR && !data_req
        ##0 !fetch_req |-> ##6 ale_q) else $error("address latch strobe missed its slot");
    a_ale_skip_data: assert property (@(posedge clock) disable iff (rst_core) // [RL3]
        is_data(cycle_q) && phase_q >= `EMBPC_SLOT_LEN |-> !ale_q) else $error("latch strobe during data access");
    a_program_fetch_strobe_internal: assert property (@(posedge clock) disable iff (rst_core) // [RL5] [RL4]
        cycle_q != EMBPC_FETCH_EXT && $past(cycle_q) != EMBPC_FETCH_EXT |-> program_fetch_strobe_n)
        else $error("fetch strobe low without external fetch");
    a_program_fetch_strobe_width: assert property (@(posedge clock) disable iff (rst_core) // [RL4]
        $fell(program_fetch_strobe_n_q) |=> !program_fetch_strobe_n_q [*2] ##1 program_fetch_strobe_n_q) else $error("fetch strobe not three periods");
    a_wr_data: assert property (@(posedge clock) disable iff (rst_core) // [RL10]
        !wr_n_q |-> p0_oe_q && p0_out_q == wdata_q) else $error("write strobe without data on port zero");
    a_rd_release: assert property (@(posedge clock) disable iff (rst_core) // [RL11] [RL9]
        !rd_n_q |-> !p0_oe_q && p2_out_q == addr_q[15:8]) else $error("read strobe with port zero driven");
    a_alt_gate: assert property (@(posedge clock) disable iff (rst_core) // [RL12]
        !p3_latch[`EMBPC_P3_CNT0] |=> !counter_zero_input) else $error("counter input active with latch zero");
    a_rts_loop: assert property (@(posedge clock) disable iff (rst_core) // [RL13]
        loop_mode |=> p1_rts_n) else $error("request to send driven in loop mode");
endmodule
`default_nettype wire

// file: verif/embpc_mem_model.sv
// External program and data memory model hanging on the multiplexed bus.
`default_nettype none
module embpc_mem_model (
    input wire logic clock,
    input wire logic address_latch_strobe,
    input wire logic program_fetch_strobe_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire embpc_pkg::embpc_byte_t p0_out,
    input wire logic p0_oe,
    input wire embpc_pkg::embpc_byte_t p2_out,
    output embpc_pkg::embpc_byte_t p0_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import embpc_pkg::*;
    embpc_addr_t addr_q;
    embpc_byte_t mem_q [0:255];
    // The external latch captures the address only while the device drives it.
    always_ff @(posedge clock) begin
        if (address_latch_strobe && p0_oe) begin
            addr_q <= {p2_out, p0_out};
        end
    end
    always_ff @(posedge clock) begin
        if (!write_strobe_n) begin
            mem_q[addr_q[7:0]] <= p0_in;
        end
    end
    // Port zero is open drain with pull-ups, so a released bus reads all ones.
    always_comb begin
        if (p0_oe) begin
            p0_in = p0_out;
        end else if (!program_fetch_strobe_n) begin
            p0_in = addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a;
        end else if (!read_strobe_n) begin
            p0_in = mem_q[addr_q[7:0]];
        end else begin
            p0_in = 8'hff;
        end
    end
endmodule
`default_nettype wire

// file: verif/embpc_top_tb.sv
// Self-checking bench for the external memory bus pin control.
`default_nettype none
module embpc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import embpc_pkg::*;
    logic clock, reset, reset_pin, core_reset, external_fetch_select, fetch_req, fetch_ready, fetch_internal;
    logic data_req, data_write, data_ready, address_latch_strobe, program_fetch_strobe_n, p0_oe, p3_0_oe, p3_1_oe;
    logic loop_mode, tx_ready, serial_tx_bit, serial_tx_enable, serial_rx_bit, diagnostic_mode, p1_cts_n, p1_rts_n;
    logic clear_to_send, ext_irq_zero, ext_irq_one, counter_zero_input, counter_one_input, serial_clock;
    embpc_addr_t fetch_pc, data_addr;
    embpc_byte_t fetch_data, data_wdata, data_rdata, p0_in, p0_out, p2_latch, p2_out, p3_latch, p3_in, p3_out;
    int bad_count = 0;
    int checked = 0;
    logic [4:0] alt_ins;
    assign alt_ins = {ext_irq_zero, ext_irq_one, counter_zero_input, counter_one_input, serial_clock};
    embpc_top u_embpc_top (.clock, .reset, .reset_pin, .core_reset, .external_fetch_select, .fetch_req, .fetch_pc,
        .fetch_ready, .fetch_internal, .fetch_data, .data_req, .data_write, .data_addr, .data_wdata, .data_ready,
        .data_rdata, .address_latch_strobe, .program_fetch_strobe_n, .p0_in, .p0_out, .p0_oe, .p2_latch, .p2_out,
        .p3_latch, .p3_in, .p3_out, .p3_0_oe, .p3_1_oe, .loop_mode, .tx_ready, .serial_tx_bit, .serial_tx_enable,
        .serial_rx_bit, .diagnostic_mode, .p1_cts_n, .p1_rts_n, .clear_to_send, .ext_irq_zero, .ext_irq_one,
        .counter_zero_input, .counter_one_input, .serial_clock);
    embpc_mem_model u_embpc_mem_model (.clock, .address_latch_strobe, .program_fetch_strobe_n,
        .write_strobe_n(p3_out[6]), .read_strobe_n(p3_out[7]), .p0_out, .p0_oe, .p2_out, .p0_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic test_idle();
        int hi = 0;
        int rise = 0;
        int lo = 0;
        logic prev;
        prev = address_latch_strobe;
        repeat (120) begin
            @(negedge clock);
            if (address_latch_strobe === 1'b1) hi++;
            if (address_latch_strobe === 1'b1 && prev === 1'b0) rise++;
            if (program_fetch_strobe_n !== 1'b1) lo++;
            prev = address_latch_strobe;
        end
        check(hi, 40);
        check(rise, 20);
        check(lo, 0);
        $display("idle strobe test done");
    endtask
    task automatic run_fetch(input embpc_addr_t pc, input logic exp_int, input logic drop);
        int n = 0;
        int lo = 0;
        fetch_pc = pc;
        fetch_req = 1'b1;
        do begin
            @(negedge clock);
            n++;
            if (program_fetch_strobe_n === 1'b0) begin
                lo++;
                check(p2_out, pc[15:8]);
            end
            if (address_latch_strobe === 1'b1 && p0_oe === 1'b1) check(p0_out, pc[7:0]);
        end while (fetch_ready !== 1'b1 && n < 40);
        if (drop) fetch_req = 1'b0;
        check(fetch_ready, 1'b1);
        check(fetch_internal, exp_int);
        check(lo, exp_int ? 0 : 3);
        if (!exp_int) check(fetch_data, pc[7:0] ^ pc[15:8] ^ 8'h5a);
    endtask
    task automatic test_fetch();
        run_fetch(16'h0fff, 1'b1, 1'b0);
        run_fetch(16'h1000, 1'b0, 1'b0);
        run_fetch(16'hfe21, 1'b0, 1'b1);
        @(negedge clock);
        external_fetch_select = 1'b0;
        run_fetch(16'h0010, 1'b0, 1'b1);
        @(negedge clock);
        external_fetch_select = 1'b1;
        $display("fetch test done");
    endtask
    task automatic run_data(input logic wr, input embpc_addr_t a, input embpc_byte_t b);
        int n = 0;
        int stb = 0;
        int other = 0;
        data_write = wr;
        data_addr = a;
        data_wdata = b;
        data_req = 1'b1;
        do begin
            @(negedge clock);
            n++;
            if (p3_out[wr ? 6 : 7] === 1'b0) begin
                stb++;
                if (address_latch_strobe === 1'b1 || program_fetch_strobe_n === 1'b0) other++;
                check(p2_out, a[15:8]);
                if (wr) check({p0_oe, p0_out}, {1'b1, b});
            end
        end while (data_ready !== 1'b1 && n < 40);
        check(data_ready, 1'b1);
        check(stb, 8);
        check(other, 0);
        if (!wr) check(data_rdata, b);
    endtask
    task automatic test_data();
        run_data(1'b1, 16'h8033, 8'ha5);
        run_data(1'b1, 16'h8034, 8'h5a);
        run_data(1'b0, 16'h8033, 8'ha5);
        run_data(1'b0, 16'h8034, 8'h5a);
        data_req = 1'b0;
        $display("data test done");
    endtask
    task automatic test_port3();
        p3_in = 8'hff;
        repeat (2) @(negedge clock);
        check(alt_ins, 5'h1f);
        p3_in = 8'hc3;
        repeat (2) @(negedge clock);
        check(alt_ins, 5'h00);
        p3_latch = 8'hc3;
        p3_in = 8'h3c;
        repeat (2) @(negedge clock);
        check(alt_ins, 5'h18);
        check(p3_out[5:2], 4'h0);
        $display("port three test done");
    endtask
    task automatic test_serial();
        p3_latch = 8'hff;
        p3_in = 8'hff;
        tx_ready = 1'b1;
        p1_cts_n = 1'b0;
        serial_tx_enable = 1'b1;
        repeat (2) @(negedge clock);
        check({p1_rts_n, clear_to_send}, 2'b01);
        check({p3_0_oe, p3_1_oe, p3_out[1:0]}, 4'hd);
        tx_ready = 1'b0;
        p1_cts_n = 1'b1;
        serial_tx_enable = 1'b0;
        repeat (2) @(negedge clock);
        check({p1_rts_n, clear_to_send, p3_1_oe, serial_rx_bit}, 4'b1001);
        loop_mode = 1'b1;
        p3_in = 8'hfe;
        repeat (2) @(negedge clock);
        check({p3_0_oe, p3_1_oe, serial_rx_bit}, 3'b010);
        loop_mode = 1'b0;
        p3_latch = 8'hfd;
        repeat (2) @(negedge clock);
        check({diagnostic_mode, p3_0_oe, p3_1_oe, serial_rx_bit}, 4'b1000);
        p3_latch = 8'hff;
        $display("serial pin test done");
    endtask
    task automatic test_reset_pin();
        reset_pin = 1'b1;
        repeat (23) @(negedge clock);
        check(core_reset, 1'b0);
        @(negedge clock);
        check(core_reset, 1'b1);
        @(negedge clock);
        check({core_reset, address_latch_strobe, program_fetch_strobe_n, p0_oe}, 4'b1010);
        reset_pin = 1'b0;
        repeat (2) @(negedge clock);
        check({core_reset, address_latch_strobe}, 2'b01);
        $display("reset pin test done");
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        reset = 1'b1;
        reset_pin = 1'b0;
        external_fetch_select = 1'b1;
        fetch_req = 1'b0;
        fetch_pc = 16'h0000;
        data_req = 1'b0;
        data_write = 1'b0;
        data_addr = 16'h0000;
        data_wdata = 8'h00;
        p2_latch = 8'h00;
        p3_latch = 8'hff;
        p3_in = 8'hff;
        loop_mode = 1'b0;
        tx_ready = 1'b0;
        serial_tx_bit = 1'b0;
        serial_tx_enable = 1'b0;
        p1_cts_n = 1'b1;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        test_idle();
        test_fetch();
        test_data();
        test_port3();
        test_serial();
        test_reset_pin();
        tally_and_finish();
    end
endmodule
`default_nettype wire
